//--- sws_consts.vh
// constants for the standby wakeup sequencer
`ifndef SWS_CONSTS_VH
`define SWS_CONSTS_VH

// register byte offsets
`define SWS_OFF_PWRDN       8'h00
`define SWS_OFF_IRQCTL      8'h04
`define SWS_OFF_WDTCTL      8'h08
`define SWS_OFF_STATE       8'h0c
`define SWS_OFF_EVSTAT      8'h10
`define SWS_OFF_EVCLR       8'h14
`define SWS_OFF_EVEN        8'h18

// field positions
`define SWS_LPE_BIT         0
`define SWS_EDGE_BIT        0
`define SWS_WDS_MSB         2
`define SWS_WDS_LSB         0

// event bit positions
`define SWS_EV_NMI_WAKE     0
`define SWS_EV_POR_EXIT     1
`define SWS_EV_MAN_EXIT     2
`define SWS_EV_SLEEP        3
`define SWS_EV_STANDBY      4
`define SWS_EV_W            5

// reset values
`define SWS_RST_LPE         1'b0
`define SWS_RST_EDGE        1'b0
`define SWS_RST_WDS         3'h0
`define SWS_RST_EVEN        5'h00

// watchdog timing: overflow after this many prescaled ticks
`define SWS_WDT_TICKS       256
// prescale divisor is this base shifted left by the delay select
`define SWS_WDT_DIV_BASE    9'h002

`endif

//--- sws_monitor.sv
// port-level assertions for the standby wakeup sequencer
`timescale 1ns/10ps
module sws_monitor #(
	parameter int WDT_TICKS = 256
) (
	// clock and reset
	input wire CORE_CLK_IN,
	input wire NRST_IN,
	// bus and pins
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PSLVERR_OUT,
	input wire CHIP_CLEAR_PIN_N_IN,
	// sequencer outputs
	input wire CPU_HALT_OUT,
	input wire NMI_EXC_REQ_OUT,
	input wire OSC_EN_OUT,
	input wire WDT_CLK_EN_OUT,
	input wire CHIP_CLK_EN_OUT,
	input wire PERIPH_HALT_OUT,
	input wire POWER_ON_RESET_OUT,
	input wire MANUAL_RESET_OUT
);
	localparam int LO = 2 * WDT_TICKS - 1;
	localparam int HI = 256 * WDT_TICKS + 1;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	logic [16:0] wcnt;
	wire         rst_st = POWER_ON_RESET_OUT || MANUAL_RESET_OUT;
	wire         waking = OSC_EN_OUT && !CHIP_CLK_EN_OUT && !rst_st;
	// cycles spent with only the watchdog clocked
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			wcnt <= 17'h00000;
		else
			wcnt <= waking ? wcnt + 17'h00001 : 17'h00000;
	end
	sequence s_exc_pulse;
		NMI_EXC_REQ_OUT && CHIP_CLK_EN_OUT && !CPU_HALT_OUT ##1 !NMI_EXC_REQ_OUT;
	endsequence
	property p_standby_halts;
		!OSC_EN_OUT |-> CPU_HALT_OUT && PERIPH_HALT_OUT && !CHIP_CLK_EN_OUT && !WDT_CLK_EN_OUT;
	endproperty
	property p_sleep_light;
		$rose(CPU_HALT_OUT) && OSC_EN_OUT |-> CHIP_CLK_EN_OUT && !PERIPH_HALT_OUT;
	endproperty
	property p_exit_causes;
		$rose(OSC_EN_OUT) |-> !CHIP_CLK_EN_OUT || rst_st;
	endproperty
	property p_wake_gates;
		$rose(OSC_EN_OUT) && !rst_st |-> WDT_CLK_EN_OUT && !CHIP_CLK_EN_OUT;
	endproperty
	property p_wake_span;
		$rose(NMI_EXC_REQ_OUT) |-> $past(wcnt) >= LO && $past(wcnt) <= HI;
	endproperty
	property p_resume;
		$rose(NMI_EXC_REQ_OUT) |-> !$past(CHIP_CLK_EN_OUT) ##0 s_exc_pulse;
	endproperty
	property p_reset_hold;
		rst_st && !CHIP_CLEAR_PIN_N_IN |=> $stable(POWER_ON_RESET_OUT) && $stable(MANUAL_RESET_OUT);
	endproperty
	property p_err_access;
		PSLVERR_OUT |-> PSEL_IN && PENABLE_IN && !(POWER_ON_RESET_OUT && MANUAL_RESET_OUT);
	endproperty
	a_standby_halts: assert property (p_standby_halts)
		else $error("standby left a clock or halt wrong");
	a_sleep_light: assert property (p_sleep_light)
		else $error("sleep halted more than the cpu");
	a_exit_causes: assert property (p_exit_causes)
		else $error("standby ended without wake or reset");
	a_wake_gates: assert property (p_wake_gates)
		else $error("wake did not clock only the watchdog");
	a_wake_span: assert property (p_wake_span)
		else $error("wake interval out of range");
	a_resume: assert property (p_resume)
		else $error("exception start malformed");
	a_reset_hold: assert property (p_reset_hold)
		else $error("reset state changed while pin low");
	a_err_access: assert property (p_err_access)
		else $error("error outside access or two reset states");
endmodule
bind sws_top sws_monitor #(.WDT_TICKS(WDT_TICKS)) i_mon (.CORE_CLK_IN, .NRST_IN, .PSEL_IN,
	.PENABLE_IN, .PSLVERR_OUT, .CHIP_CLEAR_PIN_N_IN, .CPU_HALT_OUT, .NMI_EXC_REQ_OUT,
	.OSC_EN_OUT, .WDT_CLK_EN_OUT, .CHIP_CLK_EN_OUT, .PERIPH_HALT_OUT, .POWER_ON_RESET_OUT,
	.MANUAL_RESET_OUT);

//--- sws_pins.sv
// model of the external interrupt and chip clear pin drivers
`timescale 1ns/10ps
module sws_pins (
	// clock
	input  wire        clk_in,
	// requested levels and lag in cycles
	input  wire        nmi_req_in,
	input  wire        clr_req_in,
	input  wire [3:0]  lag_in,
	// pins
	output logic       nmi_out,
	output logic       clr_n_out
);
	logic [3:0] cnt = 4'h0;
	initial nmi_out = 1'b1;
	initial clr_n_out = 1'b1;
	// a requested level reaches the pins lag_in + 1 cycles after it changes
	always @(posedge clk_in) begin
		if ({nmi_req_in, clr_req_in} == {nmi_out, clr_n_out})
			cnt <= 4'h0;
		else if (cnt < lag_in)
			cnt <= cnt + 4'h1;
		else begin
			nmi_out <= nmi_req_in;
			clr_n_out <= clr_req_in;
		end
	end
endmodule

//--- sws_sync.v
// two-flop synchroniser for an asynchronous pin level
`timescale 1ns/10ps
module sws_sync #(
	parameter INIT = 1'b0
) (
	// clock and reset
	input  wire clk_in,
	input  wire nrst_in,
	// level
	input  wire d_in,
	output wire q_out
);

	reg stage1;
	reg stage2;

	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage1 <= INIT;
			stage2 <= INIT;
		end else begin
			stage1 <= d_in;
			stage2 <= stage1;
		end
	end

	assign q_out = stage2;

endmodule

//--- sws_tb.sv
// testbench for the standby wakeup sequencer
`timescale 1ns/10ps
module standby_wakeup_sequencer_tb_top;
	localparam int T = 4;
	logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, slp = 0, irqw = 0;
	logic        nq = 1, cq = 1, er, prdy, perr, halt, exc, osc, wclk, cclk, phalt;
	logic        por, man, irq, nmi_p, clr_p;
	logic [3:0]  lag = 0;
	logic [7:0]  pa = 0;
	logic [31:0] pwd = 0, prd, rd;
	int          mismatches = 0, checked = 0;
	always #25 clk = ~clk;
	sws_top #(.WDT_TICKS(T)) i_dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
		.PREADY_OUT(prdy), .PSLVERR_OUT(perr), .SLEEP_REQ_IN(slp), .IRQ_WAKE_IN(irqw),
		.CPU_HALT_OUT(halt), .NMI_EXC_REQ_OUT(exc), .OSC_EN_OUT(osc), .WDT_CLK_EN_OUT(wclk),
		.CHIP_CLK_EN_OUT(cclk), .PERIPH_HALT_OUT(phalt), .POWER_ON_RESET_OUT(por),
		.MANUAL_RESET_OUT(man), .NMI_PIN_IN(nmi_p), .CHIP_CLEAR_PIN_N_IN(clr_p), .IRQ_OUT(irq));
	sws_pins i_pins (.clk_in(clk), .nmi_req_in(nq), .clr_req_in(cq), .lag_in(lag),
		.nmi_out(nmi_p), .clr_n_out(clr_p));
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task pin(input logic n, input logic c);
		@(posedge clk);
		nq <= n;
		cq <= c;
		repeat (lag + 3) @(posedge clk);
	endtask
	task nap;
		@(posedge clk);
		slp <= 1;
		@(posedge clk);
		slp <= 0;
		repeat (2) @(negedge clk);
	endtask
	task t_regs;
		logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
		foreach (ra[i]) begin
			apb(0, ra[i], 0);
			chk(rd, 0);
		end
		apb(0, 8'h0c, 0);
		chk(rd, 1);
		apb(1, 8'h0c, 1);
		chk(er, 1);
		apb(0, 8'h40, 0);
		chk({er, rd[30:0]}, 32'h80000000);
		$display("register test done");
	endtask
	task t_sleep;
		nap;
		chk({halt, osc, cclk, phalt}, 4'b1110);
		apb(0, 8'h10, 0);
		chk({rd[3], irq}, 2'b10);
		@(posedge clk);
		irqw <= 1;
		@(posedge clk);
		irqw <= 0;
		repeat (2) @(negedge clk);
		chk(halt, 0);
		apb(1, 8'h14, 32'h8);
		$display("sleep test done");
	endtask
	task t_stby(input logic pol, input logic [2:0] sel);
		int n;
		n = 0;
		apb(1, 8'h08, {29'h0, sel});
		apb(1, 8'h04, {31'h0, pol});
		apb(1, 8'h18, 1);
		apb(1, 8'h00, 1);
		pin(!pol, 1);
		nap;
		chk({osc, wclk, cclk, halt, phalt}, 5'b00011);
		@(posedge clk);
		irqw <= 1;
		@(posedge clk);
		irqw <= 0;
		apb(0, 8'h0c, 0);
		chk(rd, 4);
		@(posedge clk);
		nq <= pol;
		while (osc !== 1'b1) @(negedge clk);
		chk({wclk, cclk}, 2'b10);
		while (cclk !== 1'b1) begin
			n++;
			@(negedge clk);
		end
		chk(n, T * (2 << sel));
		chk({exc, halt, phalt}, 3'b100);
		@(negedge clk);
		chk({exc, irq}, 2'b01);
		apb(1, 8'h14, 1);
		@(negedge clk);
		chk(irq, 0);
		$display("standby wake test done");
	endtask
	task t_rst(input logic lv);
		apb(1, 8'h04, 0);
		apb(1, 8'h00, 1);
		pin(!lv, 1);
		nap;
		pin(lv, 1);
		repeat (6) @(negedge clk);
		chk(osc, !lv);
		if (!lv) begin
			while (cclk !== 1'b1) @(negedge clk);
			nap;
		end
		pin(lv, 0);
		repeat (6) @(negedge clk);
		chk({por, man}, {lv, !lv});
		pin(lv, 1);
		repeat (6) @(negedge clk);
		chk({por, man, halt}, 0);
		apb(0, 8'h00, 0);
		chk(rd, 0);
		apb(0, 8'h10, 0);
		chk(rd[2:1], {!lv, lv});
		apb(1, 8'h14, 32'h6);
		apb(0, 8'h10, 0);
		chk(rd[2:1], 0);
		$display("reset pin test done");
	endtask
	task close_out;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1;
		t_regs;
		t_sleep;
		t_stby(0, 3'h0);
		lag <= 5;
		t_stby(1, 3'h7);
		t_rst(1);
		t_rst(0);
		close_out;
	end
	initial begin
		#(50 * 20000);
		mismatches++;
		close_out;
	end
endmodule

//--- sws_top.v
// standby wakeup sequencer: sleep/standby control, wakeup timing, apb registers
//
// Contract
// - with the low-power entry bit set, a sleep instruction halts cpu, clock and peripherals.
// - with the low-power entry bit clear, a sleep instruction halts only the cpu.
// - standby ends only on an interrupt-pin edge, a power-on reset or a manual reset.
// - the selected interrupt-pin edge in standby restarts the oscillator, clocking only the watchdog.
// - the watchdog then counts the interval chosen by the wake-delay select set before standby.
// - on watchdog overflow the clock goes chip-wide, standby ends, and the nmi exception starts.
// - reset pin low with interrupt pin high in standby enters the power-on reset state.
// - reset pin low with interrupt pin low in standby enters the manual reset state.
// - with falling edge in force, a rising pin step before a power-on reset does not wake.
// - with falling edge in force, a falling pin step before a manual reset wakes via nmi first.
// - the edge-select bit picks falling edge at 0 and rising edge at 1.
// - after that handler, standby ends on the next selected edge of the interrupt pin, falling unless the edge-select bit is set.
`timescale 1ns/10ps
`include "sws_consts.vh"
module sws_top #(
	parameter WDT_TICKS = `SWS_WDT_TICKS
) (
	// clock and reset
	input  wire        CORE_CLK_IN,
	input  wire        NRST_IN,
	// apb slave
	input  wire        PSEL_IN,
	input  wire        PENABLE_IN,
	input  wire        PWRITE_IN,
	input  wire [7:0]  PADDR_IN,
	input  wire [31:0] PWDATA_IN,
	output reg  [31:0] PRDATA_OUT,
	output wire        PREADY_OUT,
	output wire        PSLVERR_OUT,
	// cpu side
	input  wire        SLEEP_REQ_IN,
	input  wire        IRQ_WAKE_IN,
	output reg         CPU_HALT_OUT,
	output reg         NMI_EXC_REQ_OUT,
	// clock tree
	output reg         OSC_EN_OUT,
	output reg         WDT_CLK_EN_OUT,
	output reg         CHIP_CLK_EN_OUT,
	output reg         PERIPH_HALT_OUT,
	// reset states
	output reg         POWER_ON_RESET_OUT,
	output reg         MANUAL_RESET_OUT,
	// external pins
	input  wire        NMI_PIN_IN,
	input  wire        CHIP_CLEAR_PIN_N_IN,
	// interrupt
	output wire        IRQ_OUT
);

	// one-hot states
	localparam [5:0] ST_RUN   = 6'h01;
	localparam [5:0] ST_SLEEP = 6'h02;
	localparam [5:0] ST_STBY  = 6'h04;
	localparam [5:0] ST_WAKE  = 6'h08;
	localparam [5:0] ST_POR   = 6'h10;
	localparam [5:0] ST_MAN   = 6'h20;

	localparam [15:0] WDT_LAST = WDT_TICKS[15:0] - 16'h0001;

	reg  [5:0]            state;
	reg  [5:0]            next_state;
	reg                   low_power_entry_bit;
	reg                   irq_edge_polarity_bit;
	reg  [2:0]            wake_delay_select;
	reg  [`SWS_EV_W-1:0]  ev_status;
	reg  [`SWS_EV_W-1:0]  ev_enable;
	reg  [`SWS_EV_W-1:0]  ev_set;
	reg                   nmi_prev;
	reg  [7:0]            wdt_pre;
	reg  [15:0]           wdt_count;
	wire                  nmi_lvl;
	wire                  clr_pin_n;
	wire                  nmi_rise;
	wire                  nmi_fall;
	wire                  nmi_edge;
	wire [8:0]            wdt_div;
	wire                  wdt_tick;
	wire                  wdt_ovf;
	wire                  apb_setup;
	wire                  apb_wr;
	wire                  addr_ok;
	wire                  addr_ro;
	wire                  clr_hit;
	wire                  reset_exit;

	// pin levels are resynchronised before use
	sws_sync #(.INIT(1'b1)) u_sync_nmi (
		.clk_in  (CORE_CLK_IN),
		.nrst_in (NRST_IN),
		.d_in    (NMI_PIN_IN),
		.q_out   (nmi_lvl)
	);

	sws_sync #(.INIT(1'b1)) u_sync_clr (
		.clk_in  (CORE_CLK_IN),
		.nrst_in (NRST_IN),
		.d_in    (CHIP_CLEAR_PIN_N_IN),
		.q_out   (clr_pin_n)
	);

	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			nmi_prev <= 1'b1;
		end else begin
			nmi_prev <= nmi_lvl;
		end
	end

	assign nmi_rise = ~nmi_prev & nmi_lvl;
	assign nmi_fall = nmi_prev & ~nmi_lvl;
	// polarity 0 selects falling, 1 selects rising
	assign nmi_edge = irq_edge_polarity_bit ? nmi_rise : nmi_fall;

	// watchdog prescaler: divisor doubles with each step of the delay select
	assign wdt_div  = `SWS_WDT_DIV_BASE << wake_delay_select;
	assign wdt_tick = ({1'b0, wdt_pre} + 9'h001) == wdt_div;
	assign wdt_ovf  = wdt_tick && (wdt_count == WDT_LAST);

	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			wdt_pre   <= 8'h00;
			wdt_count <= 16'h0000;
		end else if (state == ST_WAKE) begin
			if (wdt_tick) begin
				wdt_pre   <= 8'h00;
				wdt_count <= wdt_count + 16'h0001;
			end else begin
				wdt_pre <= wdt_pre + 8'h01;
			end
		end else begin
			wdt_pre   <= 8'h00;
			wdt_count <= 16'h0000;
		end
	end

	// sequencer
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (!clr_pin_n) begin
					next_state = nmi_lvl ? ST_POR : ST_MAN;
				end else if (SLEEP_REQ_IN) begin
					next_state = low_power_entry_bit ? ST_STBY : ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!clr_pin_n) begin
					next_state = nmi_lvl ? ST_POR : ST_MAN;
				end else if (IRQ_WAKE_IN || nmi_edge) begin
					next_state = ST_RUN;
				end
			end
			ST_STBY: begin
				// only three causes end standby
				if (!clr_pin_n) begin
					next_state = nmi_lvl ? ST_POR : ST_MAN;
				end else if (nmi_edge) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (!clr_pin_n) begin
					next_state = nmi_lvl ? ST_POR : ST_MAN;
				end else if (wdt_ovf) begin
					next_state = ST_RUN;
				end
			end
			ST_POR: begin
				if (clr_pin_n) begin
					next_state = ST_RUN;
				end
			end
			ST_MAN: begin
				if (clr_pin_n) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// registered outputs follow the next state
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			CPU_HALT_OUT       <= 1'b0;
			OSC_EN_OUT         <= 1'b1;
			WDT_CLK_EN_OUT     <= 1'b1;
			CHIP_CLK_EN_OUT    <= 1'b1;
			PERIPH_HALT_OUT    <= 1'b0;
			POWER_ON_RESET_OUT <= 1'b0;
			MANUAL_RESET_OUT   <= 1'b0;
			NMI_EXC_REQ_OUT    <= 1'b0;
		end else begin
			CPU_HALT_OUT       <= (next_state & (ST_SLEEP | ST_STBY | ST_WAKE)) != 6'h00;
			OSC_EN_OUT         <= next_state != ST_STBY;
			WDT_CLK_EN_OUT     <= next_state != ST_STBY;
			CHIP_CLK_EN_OUT    <= (next_state & (ST_STBY | ST_WAKE)) == 6'h00;
			PERIPH_HALT_OUT    <= (next_state & (ST_STBY | ST_WAKE)) != 6'h00;
			POWER_ON_RESET_OUT <= next_state == ST_POR;
			MANUAL_RESET_OUT   <= next_state == ST_MAN;
			NMI_EXC_REQ_OUT    <= (state == ST_WAKE) && (next_state == ST_RUN);
		end
	end

	// apb decode
	assign apb_setup   = PSEL_IN & ~PENABLE_IN;
	assign apb_wr      = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign addr_ok     = (PADDR_IN == `SWS_OFF_PWRDN) || (PADDR_IN == `SWS_OFF_IRQCTL) ||
	                     (PADDR_IN == `SWS_OFF_WDTCTL) || (PADDR_IN == `SWS_OFF_STATE) ||
	                     (PADDR_IN == `SWS_OFF_EVSTAT) || (PADDR_IN == `SWS_OFF_EVCLR) ||
	                     (PADDR_IN == `SWS_OFF_EVEN);
	assign addr_ro     = (PADDR_IN == `SWS_OFF_STATE) || (PADDR_IN == `SWS_OFF_EVSTAT);
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (~addr_ok | (PWRITE_IN & addr_ro));
	assign clr_hit     = apb_wr && (PADDR_IN == `SWS_OFF_EVCLR);
	assign reset_exit  = (state == ST_POR) || (state == ST_MAN);

	// control registers; a reset state brings the entry and edge bits back to defaults, not the delay or the event enables
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			low_power_entry_bit   <= `SWS_RST_LPE;
			irq_edge_polarity_bit <= `SWS_RST_EDGE;
			wake_delay_select     <= `SWS_RST_WDS;
			ev_enable             <= `SWS_RST_EVEN;
		end else if (reset_exit) begin
			low_power_entry_bit   <= `SWS_RST_LPE;
			irq_edge_polarity_bit <= `SWS_RST_EDGE;
		end else if (apb_wr) begin
			case (PADDR_IN)
				`SWS_OFF_PWRDN: begin
					low_power_entry_bit <= PWDATA_IN[`SWS_LPE_BIT];
				end
				`SWS_OFF_IRQCTL: begin
					irq_edge_polarity_bit <= PWDATA_IN[`SWS_EDGE_BIT];
				end
				`SWS_OFF_WDTCTL: begin
					wake_delay_select <= PWDATA_IN[`SWS_WDS_MSB:`SWS_WDS_LSB];
				end
				`SWS_OFF_EVEN: begin
					ev_enable <= PWDATA_IN[`SWS_EV_W-1:0];
				end
				default: begin
					ev_enable <= ev_enable;
				end
			endcase
		end
	end

	// sticky events; a set in the clear cycle wins
	always @* begin
		ev_set                   = {`SWS_EV_W{1'b0}};
		ev_set[`SWS_EV_NMI_WAKE] = NMI_EXC_REQ_OUT;
		ev_set[`SWS_EV_POR_EXIT] = (state == ST_POR) && (next_state == ST_RUN);
		ev_set[`SWS_EV_MAN_EXIT] = (state == ST_MAN) && (next_state == ST_RUN);
		ev_set[`SWS_EV_SLEEP]    = (state == ST_RUN) && (next_state == ST_SLEEP);
		ev_set[`SWS_EV_STANDBY]  = (state == ST_RUN) && (next_state == ST_STBY);
	end

	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ev_status <= {`SWS_EV_W{1'b0}};
		end else if (clr_hit) begin
			ev_status <= (ev_status & ~PWDATA_IN[`SWS_EV_W-1:0]) | ev_set;
		end else begin
			ev_status <= ev_status | ev_set;
		end
	end

	assign IRQ_OUT = |(ev_status & ev_enable);

	// read data is captured in the setup cycle
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			PRDATA_OUT <= 32'h00000000;
		end else if (apb_setup && !PWRITE_IN) begin
			case (PADDR_IN)
				`SWS_OFF_PWRDN: begin
					PRDATA_OUT <= {31'h00000000, low_power_entry_bit};
				end
				`SWS_OFF_IRQCTL: begin
					PRDATA_OUT <= {31'h00000000, irq_edge_polarity_bit};
				end
				`SWS_OFF_WDTCTL: begin
					PRDATA_OUT <= {29'h00000000, wake_delay_select};
				end
				`SWS_OFF_STATE: begin
					PRDATA_OUT <= {26'h0000000, state};
				end
				`SWS_OFF_EVSTAT: begin
					PRDATA_OUT <= {27'h0000000, ev_status};
				end
				`SWS_OFF_EVEN: begin
					PRDATA_OUT <= {27'h0000000, ev_enable};
				end
				default: begin
					PRDATA_OUT <= 32'h00000000;
				end
			endcase
		end
	end

endmodule
